// ---- src/iop_pkg.sv ----
// Package for the I/O port with alternate pin steering
package iop_pkg;
  localparam int IOP_PINS = 6;
  // Register byte offsets
  localparam logic [7:0] IOP_OFS_DIR = 8'h00;
  localparam logic [7:0] IOP_OFS_PIN = 8'h04;
  localparam logic [7:0] IOP_OFS_LAT = 8'h08;
  localparam logic [7:0] IOP_OFS_ANA = 8'h0C;
  localparam logic [7:0] IOP_OFS_APF = 8'h10;
  // Reset values
  localparam logic [7:0] IOP_DIR_RST = 8'h3F;
  localparam logic [7:0] IOP_LAT_RST = 8'h00;
  localparam logic [7:0] IOP_ANA_RST = 8'h17;
  localparam logic [7:0] IOP_APF_RST = 8'h00;
  localparam logic [7:0] IOP_APF_MASK = 8'hEF;
  // Steering field positions
  localparam int IOP_SEL_RX = 7;
  localparam int IOP_SEL_SDO = 6;
  localparam int IOP_SEL_SS = 5;
  localparam int IOP_SEL_TG = 3;
  localparam int IOP_SEL_TX = 2;
  localparam int IOP_SEL_PB = 1;
  localparam int IOP_SEL_PA = 0;
  // Pin indices used by steered functions
  localparam int IOP_P0 = 0;
  localparam int IOP_P1 = 1;
  localparam int IOP_P2 = 2;
  localparam int IOP_P3 = 3;
  localparam int IOP_P4 = 4;
  localparam int IOP_P5 = 5;

  // One peripheral output: enable and value
  typedef struct packed {
    logic en;
    logic dat;
  } iop_out_t;

  typedef struct packed {
    logic [7:0] adr;
    logic we;
    logic [31:0] dat;
  } iop_req_t;
endpackage : iop_pkg

// ---- src/iop_port.sv ----
// GPIO port with analog select and alternate pin steering
// Operation
// - Port has direction, pin-level and output latch registers.
// - Writing latch or pin-level register both update the output latch.
// - Reading the latch register returns latch contents.
// - Reading the pin-level register returns sampled pin levels.
// - Analog-select bits disable the digital input of a pin.
// - An enabled peripheral takes over its pin from plain I/O.
// - Steering bits put each movable function on one of two pins.
// - Steering changes never alter direction register contents.
// - Steered output and direction overrides go to the selected pin.
// - The unselected candidate pin keeps normal port behaviour.
// - Direction one disables driver; zero drives latch onto any pin but input-only pin 3.
// - Analog pins read zero through the pin-level register.
// - Highest priority function on a pin owns the pin.
//
// Added by the designer: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
module iop_port
  import iop_pkg::*;
#(
  parameter int PINS = iop_pkg::IOP_PINS
) (
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Pins
  input wire logic [PINS-1:0] pad_i,
  output logic [PINS-1:0] pad_o,
  output logic [PINS-1:0] pad_oe_n_o,
  // Peripheral outputs toward pins
  input wire iop_pkg::iop_out_t tx_i,
  input wire iop_pkg::iop_out_t sdo_i,
  input wire iop_pkg::iop_out_t pwm_a_i,
  input wire iop_pkg::iop_out_t pwm_b_i,
  // Peripheral inputs from pins, and a copy of the steering register
  output logic rx_o,
  output logic ss_o,
  output logic tgate_o,
  output logic [7:0] steer_o
);
  import iop_pkg::*;

  // Port registers
  logic [PINS-1:0] direction_reg;
  logic [PINS-1:0] output_latch_reg;
  logic [PINS-1:0] analog_select_reg;
  logic [7:0] alt_pin_function_select;

  // Pin sampling
  logic [PINS-1:0] pin_sample;
  logic [PINS-1:0] pin_level_reg;

  // Pin drive next values and overrides
  logic [PINS-1:0] next_pad;
  logic [PINS-1:0] next_oe_n;
  logic [PINS-1:0] ovr_en;
  logic [PINS-1:0] ovr_dat;

  // Steered input next values
  logic next_rx;
  logic next_ss;
  logic next_tg;

  // Bus decode
  logic [31:0] next_rdat;
  logic wr_cycle;
  logic req;
  logic rd_take;
  logic wr_dir;
  logic wr_lat;
  logic wr_ana;
  logic wr_apf;

  // Steering fields by function
  logic serial_rx_pin_choice;
  logic serial_out_pin_choice;
  logic slave_select_pin_choice;
  logic timer_gate_pin_choice;
  logic serial_tx_pin_choice;
  logic pwm_b_pin_choice;
  logic compare_pwm_a_pin_choice;

  // Candidate pin for each movable output
  logic tx_first;
  logic tx_second;
  logic sdo_first;
  logic sdo_second;
  logic pwm_b_first;
  logic pwm_b_second;
  logic pwm_a_first;
  logic pwm_a_second;

  assign req = cyc_i && stb_i && !ack_o;
  assign wr_cycle = req && we_i && sel_i[0];

  // One write strobe per register; latch and pin-level addresses share the latch strobe
  assign rd_take = ce_i && req && !we_i;
  assign wr_dir = ce_i && wr_cycle && (adr_i == IOP_OFS_DIR);
  assign wr_lat = ce_i && wr_cycle && (adr_i == IOP_OFS_LAT || adr_i == IOP_OFS_PIN);
  assign wr_ana = ce_i && wr_cycle && (adr_i == IOP_OFS_ANA);
  assign wr_apf = ce_i && wr_cycle && (adr_i == IOP_OFS_APF);

  // Steering fields by function
  assign serial_rx_pin_choice = alt_pin_function_select[IOP_SEL_RX];
  assign serial_out_pin_choice = alt_pin_function_select[IOP_SEL_SDO];
  assign slave_select_pin_choice = alt_pin_function_select[IOP_SEL_SS];
  assign timer_gate_pin_choice = alt_pin_function_select[IOP_SEL_TG];
  assign serial_tx_pin_choice = alt_pin_function_select[IOP_SEL_TX];
  assign pwm_b_pin_choice = alt_pin_function_select[IOP_SEL_PB];
  assign compare_pwm_a_pin_choice = alt_pin_function_select[IOP_SEL_PA];

  // Each enabled output lands on exactly one of its two pins
  assign tx_first = tx_i.en && !serial_tx_pin_choice;
  assign tx_second = tx_i.en && serial_tx_pin_choice;
  assign sdo_first = sdo_i.en && !serial_out_pin_choice;
  assign sdo_second = sdo_i.en && serial_out_pin_choice;
  assign pwm_b_first = pwm_b_i.en && !pwm_b_pin_choice;
  assign pwm_b_second = pwm_b_i.en && pwm_b_pin_choice;
  assign pwm_a_first = pwm_a_i.en && !compare_pwm_a_pin_choice;
  assign pwm_a_second = pwm_a_i.en && compare_pwm_a_pin_choice;

  // Sampled pins, analog pins read zero
  genvar s;
  generate
    for (s = 0; s < PINS; s++) begin : g_sample
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          pin_sample[s] <= 1'b0;
        end else if (ce_i) begin
          pin_sample[s] <= pad_i[s];
        end
      end
      assign pin_level_reg[s] = pin_sample[s] & ~analog_select_reg[s];
    end
  endgenerate

  // Direction register; steering write path does not touch it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      direction_reg <= IOP_DIR_RST[PINS-1:0];
    end else if (wr_dir) begin
      direction_reg <= dat_i[PINS-1:0];
    end
  end

  // Latch written through either latch or pin-level address
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      output_latch_reg <= IOP_LAT_RST[PINS-1:0];
    end else if (wr_lat) begin
      output_latch_reg <= dat_i[PINS-1:0];
    end
  end

  // Analog select
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      analog_select_reg <= IOP_ANA_RST[PINS-1:0];
    end else if (wr_ana) begin
      analog_select_reg <= dat_i[PINS-1:0];
    end
  end

  // Steering register, bit 4 held at zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      alt_pin_function_select <= IOP_APF_RST;
    end else if (wr_apf) begin
      alt_pin_function_select <= dat_i[7:0] & IOP_APF_MASK;
    end
  end

  // Read mux
  always_comb begin
    next_rdat = 32'h0000_0000;
    if (adr_i == IOP_OFS_DIR) begin
      next_rdat[PINS-1:0] = direction_reg;
    end else if (adr_i == IOP_OFS_PIN) begin
      next_rdat[PINS-1:0] = pin_level_reg;
    end else if (adr_i == IOP_OFS_LAT) begin
      next_rdat[PINS-1:0] = output_latch_reg;
    end else if (adr_i == IOP_OFS_ANA) begin
      next_rdat[PINS-1:0] = analog_select_reg;
    end else if (adr_i == IOP_OFS_APF) begin
      next_rdat[7:0] = alt_pin_function_select;
    end
  end

  // Acknowledge, one cycle per request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else if (ce_i) begin
      ack_o <= req;
    end
  end

  // Read data, held until the next read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (rd_take) begin
      dat_o <= next_rdat;
    end
  end

  // Per-pin override from steered outputs, first list entry wins
  always_comb begin
    ovr_en = '0;
    ovr_dat = '0;
    // Pin 0: serial tx, then serial out, then pwm b
    if (pwm_b_first) begin
      ovr_en[IOP_P0] = 1'b1;
      ovr_dat[IOP_P0] = pwm_b_i.dat;
    end
    if (sdo_first) begin
      ovr_en[IOP_P0] = 1'b1;
      ovr_dat[IOP_P0] = sdo_i.dat;
    end
    if (tx_first) begin
      ovr_en[IOP_P0] = 1'b1;
      ovr_dat[IOP_P0] = tx_i.dat;
    end

    // Pin 2: compare/pwm a
    if (pwm_a_first) begin
      ovr_en[IOP_P2] = 1'b1;
      ovr_dat[IOP_P2] = pwm_a_i.dat;
    end

    // Pin 4: serial tx, then serial out, then pwm b
    if (pwm_b_second) begin
      ovr_en[IOP_P4] = 1'b1;
      ovr_dat[IOP_P4] = pwm_b_i.dat;
    end
    if (sdo_second) begin
      ovr_en[IOP_P4] = 1'b1;
      ovr_dat[IOP_P4] = sdo_i.dat;
    end
    if (tx_second) begin
      ovr_en[IOP_P4] = 1'b1;
      ovr_dat[IOP_P4] = tx_i.dat;
    end

    // Pin 5: compare/pwm a
    if (pwm_a_second) begin
      ovr_en[IOP_P5] = 1'b1;
      ovr_dat[IOP_P5] = pwm_a_i.dat;
    end

    // Pin 3 is input only
    ovr_en[IOP_P3] = 1'b0;
  end

  // Pin drivers
  genvar g;
  generate
    for (g = 0; g < PINS; g++) begin : g_pin
      always_comb begin
        // Input-only pin never drives
        if (g == IOP_P3) begin
          next_oe_n[g] = 1'b1;
          next_pad[g] = 1'b0;

        // Steered peripheral owns the pin
        end else if (ovr_en[g]) begin
          next_oe_n[g] = 1'b0;
          next_pad[g] = ovr_dat[g];
        end else begin
          next_oe_n[g] = direction_reg[g];
          next_pad[g] = output_latch_reg[g];
        end
      end
    end
  endgenerate

  // Steered inputs take the digital level of the selected pin
  always_comb begin
    // Serial receive: pin 1 or pin 5
    next_rx = serial_rx_pin_choice ? pin_level_reg[IOP_P5] : pin_level_reg[IOP_P1];

    // Slave select: pin 3 or pin 0
    next_ss = slave_select_pin_choice ? pin_level_reg[IOP_P0] : pin_level_reg[IOP_P3];

    // Timer gate: pin 4 or pin 3
    next_tg = timer_gate_pin_choice ? pin_level_reg[IOP_P3] : pin_level_reg[IOP_P4];
  end

  // Pin drive and enable registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pad_o <= '0;
      pad_oe_n_o <= '1;
    end else if (ce_i) begin
      pad_o <= next_pad;
      pad_oe_n_o <= next_oe_n;
    end
  end

  // Steered input levels toward the peripherals
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_o <= 1'b0;
      ss_o <= 1'b0;
      tgate_o <= 1'b0;
    end else if (ce_i) begin
      rx_o <= next_rx;
      ss_o <= next_ss;
      tgate_o <= next_tg;
    end
  end

  // Copy of the steering register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      steer_o <= IOP_APF_RST;
    end else if (ce_i) begin
      steer_o <= alt_pin_function_select;
    end
  end
endmodule : iop_port

// ---- testbench/iop_pins.sv ----
// Pin-side model: outside drivers and pad resolution
`timescale 1ns/1ps
module iop_pins (
  // Port and outside drivers
  input wire logic clk_i,
  input wire logic [5:0] pad_o,
  input wire logic [5:0] pad_oe_n_o,
  input wire logic [5:0] ext_en_i,
  input wire logic [5:0] ext_val_i,
  // Resolved levels
  output logic [5:0] pad_i
);
  logic [5:0] last = 6'h00;
  always @(posedge clk_i) begin
    last <= pad_i;
  end
  // Floating pad shows the inverse of its last level
  always_comb begin
    for (int k = 0; k < 6; k++) begin
      pad_i[k] = !pad_oe_n_o[k] ? pad_o[k] : ext_en_i[k] ? ext_val_i[k] : ~last[k];
    end
  end
endmodule : iop_pins

// ---- testbench/iop_port_properties.sv ----
// Checker for the I/O port
`timescale 1ns/1ps
module iop_props
  import iop_pkg::*;
#(parameter int PINS = 6) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic ack_o,
  input wire logic [PINS-1:0] pad_o,
  input wire logic [PINS-1:0] pad_oe_n_o,
  input wire iop_out_t tx_i,
  input wire logic [7:0] steer_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [7:0] wv;
  always_ff @(posedge clk_i) begin
    if (cyc_i && stb_i && we_i && !ack_o) begin
      wv <= dat_i[7:0] & IOP_APF_MASK;
    end
  end
  sequence apf_wr;
    cyc_i && stb_i && we_i && sel_i[0] && ack_o && adr_i == IOP_OFS_APF;
  endsequence
  sequence tx_a;
    (ce_i && tx_i.en && !steer_o[IOP_SEL_TX]) [*2];
  endsequence
  sequence tx_b;
    (ce_i && tx_i.en && steer_o[IOP_SEL_TX]) [*2];
  endsequence
  a_ack_follows_req: assert property (ce_i && cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not acked");
  a_ack_one_cycle: assert property (ack_o |=> !ack_o)
    else $error("ack held too long");
  a_steer_bit4_zero: assert property (steer_o[4] == 1'b0)
    else $error("steering bit 4 set");
  a_steer_loaded: assert property (apf_wr |-> ##[0:1] steer_o == wv)
    else $error("steering value not loaded");
  a_steer_hold: assert property ((!(cyc_i && we_i)) [*2] |=> $stable(steer_o))
    else $error("steering changed without write");
  a_pin3_undriven: assert property (pad_oe_n_o[IOP_P3])
    else $error("input-only pin driven");
  a_tx_first_pin: assert property (tx_a ##1 !steer_o[IOP_SEL_TX] |->
    !pad_oe_n_o[IOP_P0] && pad_o[IOP_P0] == $past(tx_i.dat))
    else $error("transmit not on first pin");
  a_tx_second_pin: assert property (tx_b ##1 steer_o[IOP_SEL_TX] |->
    !pad_oe_n_o[IOP_P4] && pad_o[IOP_P4] == $past(tx_i.dat))
    else $error("transmit not on second pin");
endmodule : iop_props
bind iop_port iop_props #(.PINS(PINS)) u_props (.clk_i, .rst_i, .ce_i, .cyc_i, .stb_i, .we_i,
  .adr_i, .sel_i, .dat_i, .ack_o, .pad_o, .pad_oe_n_o, .tx_i, .steer_o);

// ---- testbench/tb.sv ----
// Testbench for the I/O port
`timescale 1ns/1ps
module tb;
  import iop_pkg::*;
  logic clk_i = 0, rst_i = 1, ce_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
  logic [7:0] adr_i = 0, steer_o;
  logic [3:0] sel_i = 0;
  logic [31:0] dat_i = 0, dat_o, v, exq[$];
  logic ack_o, rx_o, ss_o, tgate_o;
  logic [5:0] pad_i, pad_o, pad_oe_n_o, xen = 0, xv = 0;
  iop_out_t tx_i = 0, sdo_i = 0, pwm_a_i = 0, pwm_b_i = 0;
  int err_total = 0, tests_run = 0, cyc_n = 0;
  always #5 clk_i = ~clk_i;
  iop_port dut (.clk_i, .rst_i, .ce_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
    .ack_o, .pad_i, .pad_o, .pad_oe_n_o, .tx_i, .sdo_i, .pwm_a_i, .pwm_b_i, .rx_o, .ss_o,
    .tgate_o, .steer_o);
  iop_pins pm (.clk_i, .pad_o, .pad_oe_n_o, .ext_en_i(xen), .ext_val_i(xv), .pad_i);
  task automatic report_and_stop();
    $display("tests %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'b11, w, a, 4'hF, d};
    do @(posedge clk_i); while (ack_o !== 1'b1);
    {cyc_i, stb_i} <= 2'b00;
    @(posedge clk_i);
  endtask : wb
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exq.push_back(e);
    wb(1'b0, a, 0);
  endtask : rd
  // Read data checked against the oldest expectation
  always @(posedge clk_i) begin
    cyc_n++;
    if (ack_o === 1'b1 && we_i === 1'b0) begin
      chk(dat_o, exq.pop_front());
    end
    if (cyc_n > 3000) begin
      err_total++;
      report_and_stop();
    end
  end
  initial begin
    void'($urandom(17018));
    repeat (5) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    rd(IOP_OFS_DIR, 8'h3F);
    rd(IOP_OFS_LAT, 8'h00);
    rd(IOP_OFS_ANA, 8'h17);
    rd(IOP_OFS_APF, 8'h00);
    rd(8'h14, 8'h00);
    $display("test 1 done");
    wb(1, IOP_OFS_APF, 8'hFF);
    rd(IOP_OFS_APF, 8'hEF);
    rd(IOP_OFS_DIR, 8'h3F);
    $display("test 2 done");
    xen <= 6'h08;
    wb(1, IOP_OFS_APF, 0);
    wb(1, IOP_OFS_ANA, 0);
    wb(1, IOP_OFS_DIR, 0);
    v = $urandom & 8'h3F;
    wb(1, IOP_OFS_PIN, v);
    rd(IOP_OFS_LAT, v);
    chk(pad_o & 8'h37, v & 8'h37);
    chk(pad_oe_n_o, 8'h08);
    rd(IOP_OFS_PIN, v & 8'h37);
    $display("test 3 done");
    wb(1, IOP_OFS_DIR, 8'h3F);
    xen <= 6'h3F;
    xv <= ~v[5:0];
    rd(IOP_OFS_LAT, v);
    rd(IOP_OFS_PIN, ~v & 8'h3F);
    wb(1, IOP_OFS_ANA, 8'h3F);
    rd(IOP_OFS_PIN, 0);
    wb(1, IOP_OFS_ANA, 0);
    $display("test 4 done");
    for (int s = 0; s < 2; s++) begin
      v = $urandom;
      xv <= v[5:0];
      tx_i <= {1'b1, v[6]};
      sdo_i <= {1'b1, ~v[6]};
      pwm_a_i <= {1'b1, v[7]};
      wb(1, IOP_OFS_APF, s ? 8'hEF : 8'h00);
      repeat (3) @(posedge clk_i);
      chk(pad_oe_n_o, s ? 8'h0F : 8'h3A);
      chk(pad_o[s ? 5 : 2], v[7]);
      chk(pad_o[s ? 4 : 0], v[6]);
      chk(rx_o, s ? v[7] : v[1]);
      chk(ss_o, s ? v[0] : v[3]);
      chk(tgate_o, s ? v[3] : v[4]);
    end
    $display("test 5 done");
    rst_i <= 1;
    repeat (5) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    rd(IOP_OFS_APF, 8'h00);
    rd(IOP_OFS_LAT, 8'h00);
    $display("test 6 done");
    report_and_stop();
  end
endmodule : tb
